// >>> rtl/sarwc_clkdiv.v
// Conversion clock enable divider
`timescale 1ns/10ps
module sarwc_clkdiv #(
    parameter WIDTH = 5
) (
    input wire clk,
    input wire rstn,
    input wire run,
    input wire [WIDTH-1:0] divide,
    output reg tick
);
    reg [WIDTH-1:0] count_reg;
    // ----------------------------------------
    // Divide by field plus one
    // ----------------------------------------
    // Restarts at each run so the first tick is a full period away
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= {WIDTH{1'b0}};
            tick <= 1'b0;
        end else if (!run) begin
            count_reg <= {WIDTH{1'b0}};
            tick <= 1'b0;
        end else if (count_reg >= divide) begin
            count_reg <= {WIDTH{1'b0}};
            tick <= 1'b1;
        end else begin
            count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end
endmodule

// >>> rtl/sarwc_defs.vh
// Register map, field positions, reset values and timing counts for the converter control
`ifndef SARWC_DEFS_VH
`define SARWC_DEFS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define SARWC_ADDR_CONFIG 8'hbc
`define SARWC_ADDR_RESULT 8'hbe
`define SARWC_ADDR_CONTROL 8'he8
`define SARWC_ADDR_GREATER 8'hc4
`define SARWC_ADDR_LESS 8'hc6
`define SARWC_ADDR_PAIRCFG 8'hba
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SARWC_RST_CONFIG 8'hf8
`define SARWC_RST_RESULT 8'h00
`define SARWC_RST_CONTROL 8'h00
`define SARWC_RST_GREATER 8'hff
`define SARWC_RST_LESS 8'h00
`define SARWC_RST_PAIRCFG 4'h0
// ----------------------------------------
// Control register bits
// ----------------------------------------
`define SARWC_BIT_ENABLE 7
`define SARWC_BIT_LPTRACK 6
`define SARWC_BIT_DONE 5
`define SARWC_BIT_BUSY 4
`define SARWC_BIT_MODE_HI 3
`define SARWC_BIT_MODE_LO 1
`define SARWC_BIT_WINDOW 0
// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define SARWC_DIV_HI 7
`define SARWC_DIV_LO 3
`define SARWC_CFG_UNUSED_MASK 8'hfb
// ----------------------------------------
// Start trigger codes
// ----------------------------------------
`define SARWC_TRIG_SOFT 3'h0
`define SARWC_TRIG_TIMER3 3'h1
`define SARWC_TRIG_EXT 3'h2
`define SARWC_TRIG_TIMER2 3'h3
// ----------------------------------------
// Timing in conversion clocks
// ----------------------------------------
`define SARWC_TRACK_CLOCKS 4'h3
`define SARWC_CONV_CLOCKS 4'h8
`endif

// >>> rtl/sarwc_top.v
// Control logic for an 8-bit successive-approximation converter with window detect
// Function
// - Conversion clock is system clock divided by divider field plus one.
// - Gain field selects half, unity, two or four.
// - Config bit 2 reads zero, writes ignored.
// - Enable clear means shutdown; set means active and ready.
// - Normal mode tracks continuously except during conversion.
// - Done flag set on completion, cleared only by software.
// - Done flag set when busy falls at conversion end, not when disable aborts.
// - Busy reads one during conversion and timed low-power tracking, else zero.
// - Busy write zero ignored; one starts only in soft mode.
// - Start mode selects soft, timer 3, external edge, timer 2, other converter.
// - Low-power mode tracks three conversion clocks, then converts.
// - Low-power external mode tracks while input low, converts on rise.
// - Window flag set on match, cleared only by software.
// - Own start input used when enabled, else shared input.
// - Single-ended result is unsigned code.
// - Differential result is two's complement code.
// - Every result compared against greater and less limits.
// - Less above greater: match strictly inside.
// - Otherwise: match strictly outside.
// - Conversion lasts at least eight conversion clocks.
// - Pair bit set joins the two inputs as one differential input.
// - Differential channels give two's complement result.
`timescale 1ns/10ps
`include "sarwc_defs.vh"
module sarwc_top #(
    parameter DIV_WIDTH = 5,
    parameter CONV_WIDTH = 8
) (
    input wire clk,
    input wire rstn,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire timer3_overflow,
    input wire timer2_overflow,
    input wire other_converter_busy,
    input wire ext_start_own,
    input wire ext_start_shared,
    input wire own_start_routed,
    input wire [2:0] channel_select,
    input wire [CONV_WIDTH-1:0] sar_result,
    output reg converter_powered,
    output reg track_active,
    output reg convert_active,
    output reg [1:0] amplifier_gain_select,
    output reg [3:0] input_pair_config,
    output reg channel_differential
);
    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_TRACK = 2'h1;
    localparam ST_CONV = 2'h2;

    reg [7:0] config_reg;
    reg [7:0] control_reg;
    reg [7:0] result_reg;
    reg [7:0] greater_reg;
    reg [7:0] less_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [3:0] clocks_reg;
    reg ext_meta_own_reg;
    reg ext_sync_own_reg;
    reg ext_meta_sh_reg;
    reg ext_sync_sh_reg;
    reg ext_last_reg;
    reg route_meta_reg;
    reg route_sync_reg;
    wire conv_tick;
    wire window_hit;
    wire ext_level;
    wire ext_rise;

    // Control fields
    wire enable = control_reg[`SARWC_BIT_ENABLE];
    wire lp_mode = control_reg[`SARWC_BIT_LPTRACK];
    wire [2:0] trig_mode = control_reg[`SARWC_BIT_MODE_HI:`SARWC_BIT_MODE_LO];

    // ----------------------------------------
    // Busy as software sees it
    // ----------------------------------------
    // Low-power external mode waits on the pin, so its tracking phase is not busy
    wire ext_lp_mode = lp_mode && (trig_mode == `SARWC_TRIG_EXT);
    wire busy = (state_reg != ST_IDLE) && !(ext_lp_mode && state_reg == ST_TRACK);

    // Bus decode helper, used for every register
    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // Pair bit for the selected channel
    function pair_bit;
        input [3:0] pairs;
        input [2:0] chan;
        begin
            pair_bit = pairs[chan[2:1]];
        end
    endfunction

    // ----------------------------------------
    // External start synchronisers
    // ----------------------------------------
    // Pins are asynchronous; two flops each before any logic reads them
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_meta_own_reg <= 1'b0;
            ext_sync_own_reg <= 1'b0;
            ext_meta_sh_reg <= 1'b0;
            ext_sync_sh_reg <= 1'b0;
            route_meta_reg <= 1'b0;
            route_sync_reg <= 1'b0;
            ext_last_reg <= 1'b0;
        end else begin
            ext_meta_own_reg <= ext_start_own;
            ext_sync_own_reg <= ext_meta_own_reg;
            ext_meta_sh_reg <= ext_start_shared;
            ext_sync_sh_reg <= ext_meta_sh_reg;
            route_meta_reg <= own_start_routed;
            route_sync_reg <= route_meta_reg;
            ext_last_reg <= ext_level;
        end
    end

    // Source choice follows the crossbar routing
    assign ext_level = route_sync_reg ? ext_sync_own_reg : ext_sync_sh_reg;
    // Edge memory resets low like the synchronisers, so no false edge at reset
    assign ext_rise = ext_level && !ext_last_reg;

    // Bus writes of one to the busy bit in soft start mode
    wire wr_control = reg_wr && hit(reg_addr, `SARWC_ADDR_CONTROL);
    wire soft_start = wr_control && reg_wdata[`SARWC_BIT_BUSY]
        && trig_mode == `SARWC_TRIG_SOFT;

    // ----------------------------------------
    // Trigger selection
    // ----------------------------------------
    // Timer and other-converter inputs are same-clock pulses, read directly
    reg trigger;
    always @* begin
        case (trig_mode)
            `SARWC_TRIG_SOFT: trigger = soft_start;
            `SARWC_TRIG_TIMER3: trigger = timer3_overflow;
            `SARWC_TRIG_EXT: trigger = ext_rise;
            `SARWC_TRIG_TIMER2: trigger = timer2_overflow;
            default: trigger = other_converter_busy;
        endcase
    end

    // Divider only runs while enabled, saving power in shutdown.
    // It also restarts on every phase change, so tracking and conversion
    // each span whole conversion clocks rather than a cut first period.
    wire div_run = enable && (state_next == state_reg);
    sarwc_clkdiv #(
        .WIDTH(DIV_WIDTH)
    ) u_div (
        .clk(clk),
        .rstn(rstn),
        .run(div_run),
        .divide(config_reg[`SARWC_DIV_HI:`SARWC_DIV_LO]),
        .tick(conv_tick)
    );

    // ----------------------------------------
    // Sequencer next state
    // ----------------------------------------
    always @* begin
        state_next = state_reg;
        if (!enable) begin
            state_next = ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (lp_mode && trig_mode == `SARWC_TRIG_EXT) begin
                        state_next = ext_level ? ST_IDLE : ST_TRACK;
                    end else if (trigger) begin
                        state_next = lp_mode ? ST_TRACK : ST_CONV;
                    end
                end
                ST_TRACK: begin
                    if (lp_mode && trig_mode == `SARWC_TRIG_EXT) begin
                        if (ext_rise) begin
                            state_next = ST_CONV;
                        end
                    end else if (conv_tick && clocks_reg == `SARWC_TRACK_CLOCKS - 4'h1) begin
                        state_next = ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_tick && clocks_reg == `SARWC_CONV_CLOCKS - 4'h1) begin
                        state_next = ST_IDLE;
                    end
                end
                default: state_next = ST_IDLE;
            endcase
        end
    end

    // Disabling mid-conversion aborts without counting as completion
    wire conv_done = state_reg == ST_CONV && state_next == ST_IDLE && enable;

    // ----------------------------------------
    // Sequencer registers and pin outputs
    // ----------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            clocks_reg <= 4'h0;
            converter_powered <= 1'b0;
            track_active <= 1'b0;
            convert_active <= 1'b0;
            amplifier_gain_select <= 2'h0;
            input_pair_config <= `SARWC_RST_PAIRCFG;
            channel_differential <= 1'b0;
        end else begin
            state_reg <= state_next;
            // Phase counter restarts with the divider on every phase change
            if (state_next != state_reg) begin
                clocks_reg <= 4'h0;
            end else if (conv_tick) begin
                clocks_reg <= clocks_reg + 4'h1;
            end
            converter_powered <= enable;
            // Normal mode tracks whenever not converting
            track_active <= enable && ((!lp_mode && state_next != ST_CONV)
                || state_next == ST_TRACK);
            convert_active <= state_next == ST_CONV;
            amplifier_gain_select <= config_reg[1:0];
            channel_differential <= pair_bit(input_pair_config, channel_select);
            if (reg_wr && hit(reg_addr, `SARWC_ADDR_PAIRCFG)) begin
                input_pair_config <= reg_wdata[3:0];
            end
        end
    end

    // Analog core delivers the code already in the mode's format
    wire [7:0] new_result = sar_result[CONV_WIDTH-1:CONV_WIDTH-8];

    sarwc_window u_win (
        .result(new_result),
        .signed_mode(channel_differential),
        .greater_limit(greater_reg),
        .less_limit(less_reg),
        .match(window_hit)
    );

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    // Hardware set beats a software clear in the same cycle
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            config_reg <= `SARWC_RST_CONFIG;
            control_reg <= `SARWC_RST_CONTROL;
        end else begin
            if (reg_wr && hit(reg_addr, `SARWC_ADDR_CONFIG)) begin
                config_reg <= reg_wdata & `SARWC_CFG_UNUSED_MASK;
            end
            if (wr_control) begin
                control_reg[7:6] <= reg_wdata[7:6];
                control_reg[3:1] <= reg_wdata[3:1];
                control_reg[`SARWC_BIT_DONE] <= reg_wdata[`SARWC_BIT_DONE];
                control_reg[`SARWC_BIT_WINDOW] <= reg_wdata[`SARWC_BIT_WINDOW];
            end
            control_reg[`SARWC_BIT_BUSY] <= 1'b0;
            if (conv_done) begin
                control_reg[`SARWC_BIT_DONE] <= 1'b1;
                if (window_hit) begin
                    control_reg[`SARWC_BIT_WINDOW] <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Window limit registers
    // ----------------------------------------
    // Reset limits leave the window unable to match a single-ended code
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            greater_reg <= `SARWC_RST_GREATER;
            less_reg <= `SARWC_RST_LESS;
        end else begin
            if (reg_wr && hit(reg_addr, `SARWC_ADDR_GREATER)) begin
                greater_reg <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, `SARWC_ADDR_LESS)) begin
                less_reg <= reg_wdata;
            end
        end
    end

    // ----------------------------------------
    // Result register
    // ----------------------------------------
    // A finishing conversion beats a software write in the same cycle
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            result_reg <= `SARWC_RST_RESULT;
        end else if (conv_done) begin
            result_reg <= new_result;
        end else if (reg_wr && hit(reg_addr, `SARWC_ADDR_RESULT)) begin
            result_reg <= reg_wdata;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Unmapped addresses read zero
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (hit(reg_addr, `SARWC_ADDR_CONFIG)) begin
                reg_rdata <= config_reg;
            end else if (hit(reg_addr, `SARWC_ADDR_CONTROL)) begin
                reg_rdata <= {control_reg[7:5], busy, control_reg[3:0]};
            end else if (hit(reg_addr, `SARWC_ADDR_RESULT)) begin
                reg_rdata <= result_reg;
            end else if (hit(reg_addr, `SARWC_ADDR_GREATER)) begin
                reg_rdata <= greater_reg;
            end else if (hit(reg_addr, `SARWC_ADDR_LESS)) begin
                reg_rdata <= less_reg;
            end else if (hit(reg_addr, `SARWC_ADDR_PAIRCFG)) begin
                reg_rdata <= {4'h0, input_pair_config};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end
endmodule

// >>> rtl/sarwc_window.v
// Window comparator for each new result
`timescale 1ns/10ps
module sarwc_window (
    input wire [7:0] result,
    input wire signed_mode,
    input wire [7:0] greater_limit,
    input wire [7:0] less_limit,
    output wire match
);
    // Signed compare via flipping the sign bit
    wire [7:0] r_cmp = {result[7] ^ signed_mode, result[6:0]};
    wire [7:0] g_cmp = {greater_limit[7] ^ signed_mode, greater_limit[6:0]};
    wire [7:0] l_cmp = {less_limit[7] ^ signed_mode, less_limit[6:0]};
    wire above = r_cmp > g_cmp;
    wire below = r_cmp < l_cmp;
    // ----------------------------------------
    // Inside when less exceeds greater, outside otherwise
    // ----------------------------------------
    assign match = (l_cmp > g_cmp) ? (above && below) : (above || below);
endmodule

// >>> verification/sarwc_props.sv
// Concurrent checks on the converter control ports
`timescale 1ns/10ps
module sarwc_props (
    input wire clk,
    input wire rstn,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [2:0] channel_select,
    input wire converter_powered,
    input wire track_active,
    input wire convert_active,
    input wire [1:0] amplifier_gain_select,
    input wire [3:0] input_pair_config,
    input wire channel_differential
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Shadow of the last control write; mode and track bits are software-only
    reg [7:0] ctl_shadow;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_shadow <= 8'h00;
        end else if (reg_wr && reg_addr == 8'he8) begin
            ctl_shadow <= reg_wdata;
        end
    end
    // Tracking stops whenever a conversion runs
    property p_excl; !(track_active && convert_active); endproperty
    a_excl: assert property (p_excl) else $error("track and convert overlap");
    property p_bit2; reg_rd && reg_addr == 8'hbc |=> !reg_rdata[2]; endproperty
    a_bit2: assert property (p_bit2) else $error("config bit 2 reads one");
    property p_conv8; $rose(convert_active) |-> convert_active [*8]; endproperty
    a_conv8: assert property (p_conv8) else $error("conversion too short");
    // Soft start from idle must launch within two cycles
    property p_soft;
        reg_wr && reg_addr == 8'he8 && reg_wdata == 8'h90 && converter_powered
            && !convert_active && !ctl_shadow[6] && ctl_shadow[3:1] == 3'h0
            |-> ##[1:2] convert_active;
    endproperty
    a_soft: assert property (p_soft) else $error("soft start missed");
    property p_gain;
        reg_wr && reg_addr == 8'hbc && reg_wdata[1:0] == 2'h2
            |-> ##[1:2] amplifier_gain_select == 2'h2;
    endproperty
    a_gain: assert property (p_gain) else $error("gain not applied");
    property p_pwr; reg_wr && reg_addr == 8'he8 && reg_wdata[7] |-> ##[1:2] converter_powered;
    endproperty
    a_pwr: assert property (p_pwr) else $error("enable not applied");
    // Shutdown leaves the input neither tracking nor converting
    property p_off; !converter_powered [*3] |-> !convert_active && !track_active; endproperty
    a_off: assert property (p_off) else $error("activity while shut down");
    property p_diff;
        $stable(channel_select) && $stable(input_pair_config) ##1 $stable(channel_select)
            && $stable(input_pair_config)
            |-> channel_differential == input_pair_config[channel_select[2:1]];
    endproperty
    a_diff: assert property (p_diff) else $error("pair flag mismatch");
    c_conv: cover property ($rose(convert_active));
    c_track: cover property ($fell(track_active));
    c_diff: cover property (channel_differential);
endmodule
bind sarwc_top sarwc_props u_props (
    .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .channel_select(channel_select),
    .converter_powered(converter_powered), .track_active(track_active),
    .convert_active(convert_active), .amplifier_gain_select(amplifier_gain_select),
    .input_pair_config(input_pair_config), .channel_differential(channel_differential)
);

// >>> verification/tb_top.sv
// Self-checking testbench for the converter control block
`timescale 1ns/10ps
module tb_top;
    reg clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
    reg [7:0] reg_addr = 0, reg_wdata = 0, sar_result = 0, d;
    reg t3 = 0, t2 = 0, ob = 0, eo = 0, es = 0, routed = 0;
    reg [2:0] chan = 0;
    wire [7:0] reg_rdata;
    wire pw, trk, cnv, dif;
    wire [1:0] gain;
    wire [3:0] pairs;
    integer error_cnt = 0, comparisons = 0, cyc = 0;
    sarwc_top dut (
        .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer3_overflow(t3),
        .timer2_overflow(t2), .other_converter_busy(ob), .ext_start_own(eo),
        .ext_start_shared(es), .own_start_routed(routed), .channel_select(chan),
        .sar_result(sar_result), .converter_powered(pw), .track_active(trk),
        .convert_active(cnv), .amplifier_gain_select(gain), .input_pair_config(pairs),
        .channel_differential(dif)
    );
    // ----------------------------------------
    // Clock, watchdog and shared tasks
    // ----------------------------------------
    initial begin
        forever #20 clk = ~clk;
    end
    // Cuts a hang short; the whole run needs well under 3000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt = error_cnt + 1;
            report_and_stop;
        end
    end
    task report_and_stop;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task step;
        @(posedge clk);
        #1;
    endtask
    // Idle cycle after each strobe so no strobe is driven twice at once
    task wr(input [7:0] a, input [7:0] v);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = v;
        step;
        reg_wr = 0;
        step;
    endtask
    task rd(input [7:0] a);
        reg_rd = 1;
        reg_addr = a;
        step;
        d = reg_rdata;
        reg_rd = 0;
        step;
    endtask
    // Start delay in cycles (40 = none) and length of the conversion
    task conv(output integer st, output integer len);
        st = 0;
        len = 0;
        while (cnv !== 1'b1 && st < 40) begin
            step;
            st = st + 1;
        end
        if (cnv === 1'b1) begin
            rd(8'he8);
            chk("done and busy", d[5:4], 2'b01);
            len = 2;
            while (cnv === 1'b1 && len < 80) begin
                step;
                len = len + 1;
            end
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        reg [7:0] a [0:6];
        reg [7:0] e [0:6];
        integer i;
        a = '{8'hbc, 8'hbe, 8'he8, 8'hc4, 8'hc6, 8'hba, 8'h01};
        e = '{8'hf8, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
        for (i = 0; i < 7; i = i + 1) begin
            rd(a[i]);
            chk("reset value", d, e[i]);
        end
        chk("powered", pw, 0);
    endtask
    task t_cfg;
        integer g;
        wr(8'hbc, 8'hff);
        rd(8'hbc);
        chk("config", d, 8'hfb);
        for (g = 0; g < 4; g = g + 1) begin
            wr(8'hbc, 8'h08 | g[7:0]);
            chk("gain", gain, g[1:0]);
        end
    endtask
    // Divider field 1 gives two clocks per conversion clock
    task t_soft;
        integer st, len;
        wr(8'he8, 8'h80);
        chk("idle track", trk, 1);
        chk("powered on", pw, 1);
        sar_result = 8'h5a;
        wr(8'he8, 8'h80);
        conv(st, len);
        chk("zero busy write", st, 40);
        wr(8'he8, 8'h90);
        conv(st, len);
        chk("length", len >= 15 && len <= 17, 1);
        rd(8'he8);
        chk("control", d, 8'ha0);
        rd(8'hbe);
        chk("result", d, 8'h5a);
    endtask
    task t_win;
        reg [24:0] w [0:4];
        integer i, st, len;
        w = '{{8'h10, 8'h20, 8'h18, 1'b1}, {8'h10, 8'h20, 8'h20, 1'b0},
              {8'h20, 8'h10, 8'h21, 1'b1}, {8'h20, 8'h10, 8'h10, 1'b0},
              {8'h20, 8'h10, 8'h0f, 1'b1}};
        for (i = 0; i < 5; i = i + 1) begin
            wr(8'hc4, w[i][24:17]);
            wr(8'hc6, w[i][16:9]);
            sar_result = w[i][8:1];
            wr(8'he8, 8'h90);
            conv(st, len);
            rd(8'he8);
            chk("window flag", d[0], w[i][0]);
        end
    endtask
    task t_trig;
        integer m, st, len;
        for (m = 1; m < 5; m = m + 1) begin
            wr(8'he8, 8'h80 | (m[7:0] << 1));
            wr(8'he8, 8'h90 | (m[7:0] << 1));
            conv(st, len);
            chk("busy write ignored", st, 40);
            case (m)
                1: t3 = 1;
                2: es = 1;
                3: t2 = 1;
                default: ob = 1;
            endcase
            step;
            t3 = 0;
            t2 = 0;
            ob = 0;
            conv(st, len);
            es = 0;
            chk("trigger start", st < 40, 1);
        end
        routed = 1;
        wr(8'he8, 8'h84);
        repeat (4) step;
        es = 1;
        conv(st, len);
        chk("shared ignored", st, 40);
        eo = 1;
        conv(st, len);
        chk("own start", st < 40, 1);
        es = 0;
        eo = 0;
    endtask
    task t_lp;
        integer st, len;
        wr(8'he8, 8'hc0);
        wr(8'he8, 8'hd0);
        chk("lp track", trk, 1);
        conv(st, len);
        chk("track span", st >= 3 && st <= 6, 1);
        wr(8'he8, 8'hc4);
        repeat (4) step;
        chk("ext track", trk, 1);
        eo = 1;
        conv(st, len);
        chk("ext start", st < 40, 1);
        chk("hold high", trk, 0);
        eo = 0;
    endtask
    // Abort by disable mid-conversion, then the pair selection
    task t_pair;
        wr(8'he8, 8'h80);
        wr(8'he8, 8'h90);
        wr(8'he8, 8'h00);
        step;
        rd(8'he8);
        chk("aborted", d, 8'h00);
        chk("off track", trk, 0);
        wr(8'hba, 8'h01);
        chan = 3'h1;
        repeat (2) step;
        chk("differential", dif, 1);
        chan = 3'h2;
        repeat (2) step;
        chk("single ended", dif, 0);
        chk("pair config", pairs, 4'h1);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rstn = 1;
        step;
        t_regs;
        t_cfg;
        t_soft;
        t_win;
        t_trig;
        t_lp;
        t_pair;
        report_and_stop;
    end
endmodule
